// [pkg/rif_pkg.sv]
`default_nettype none
package rif_pkg;
  // register port geometry
  localparam int unsigned REG_ADDR_W = 10;
  localparam int unsigned REG_DATA_W = 8;
  localparam int unsigned SRC_BYTES = 3;
  localparam int unsigned SRC_BITS = 24;

  // register offsets
  localparam logic [9:0] ADDR_OUT_MODE = 10'h0F2;
  localparam logic [9:0] ADDR_SRC0 = 10'h0F4;
  localparam logic [9:0] ADDR_SRC1 = 10'h0F5;
  localparam logic [9:0] ADDR_SRC2 = 10'h0F6;

  // output mode register layout
  localparam int unsigned MODE_POL_BIT = 0;
  localparam int unsigned MODE_DONE_CLR_BIT = 3;
  localparam int unsigned MODE_SLOT_A_BIT = 4;
  localparam int unsigned MODE_SLOT_B_BIT = 5;
  localparam int unsigned MODE_SLOT_C_BIT = 6;
  localparam int unsigned MODE_ABORT_CLR_BIT = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WR_MASK = 8'hF9;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;

  // flag positions in the 24-bit source vector, byte n at [8n+7:8n]
  localparam int unsigned F_TIM0 = 0;
  localparam int unsigned F_TIM1 = 1;
  localparam int unsigned F_TIM2 = 2;
  localparam int unsigned F_CAL = 3;
  localparam int unsigned F_TX0 = 4;
  localparam int unsigned F_TX1 = 5;
  localparam int unsigned F_FSYNC = 6;
  localparam int unsigned F_CSMA = 7;
  localparam int unsigned F_RX0 = 8;
  localparam int unsigned F_RX1 = 9;
  localparam int unsigned F_FLEN = 10;
  localparam int unsigned F_ADDR = 11;
  localparam int unsigned F_OVR = 12;
  localparam int unsigned F_MODESW = 13;
  localparam int unsigned F_RXLVL = 14;
  localparam int unsigned F_TXFIN = 15;
  localparam int unsigned F_TXBYTE = 16;
  localparam int unsigned F_TXSTART = 17;
  localparam int unsigned F_RXSTART = 18;
  localparam int unsigned F_RXFIN = 19;
  localparam int unsigned F_RXBYTE = 20;
  localparam int unsigned F_AGC = 21;
  localparam int unsigned F_CCA = 22;
  localparam int unsigned F_PREAMB = 23;

  // flags wiped at reception completion and at reception cancel
  localparam logic [23:0] DONE_CLR_MASK = 24'hA40C00;
  localparam logic [23:0] ABORT_CLR_MASK = 24'hB40F00;
endpackage
`default_nettype wire

// [design/rif_flag_bank.sv]
`default_nettype none
module rif_flag_bank
  import rif_pkg::*;
#(
  parameter int unsigned NBITS = SRC_BITS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // set and clear requests
  input wire logic [NBITS-1:0] set_i,
  input wire logic [NBITS-1:0] clr_i,
  // held flags
  output logic [NBITS-1:0] flags_o
);

  if (NBITS == 0) begin : g_bad
    $error("rif_flag_bank needs at least one flag");
  end

  // one sticky flag per bit; a set in the clear cycle survives
  for (genvar i = 0; i < NBITS; i++) begin : g_flag
    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        flags_o[i] <= 1'b0;
      end else if (set_i[i]) begin
        flags_o[i] <= 1'b1;
      end else if (clr_i[i]) begin
        flags_o[i] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [design/rif_top.sv]
// Function
// - polarity bit 0 high-active, 1 low-active
// - completion clearing wipes listed receive flags
// - cancel clearing wipes listed receive flags
// - slot A picks CSMA-CA or CCA completion
// - slot B picks frame length or address
// - slot C picks CCA clearance or cancel
// - mode register resets to zero, fixed layout
// - enabled source event sets its flag
// - flag clears after read as one, or by an enabled completion or cancel wipe
// - source contents after reset not guaranteed
// - source byte 0 layout: csma..timer0
// - source byte 1 layout: tx fin..rx0
// - source byte 2 layout: preamble..tx bytes
`default_nettype none
module rif_top
  import rif_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // register port from the serial decoder
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  output logic [REG_DATA_W-1:0] reg_rdata_o,
  // byte 0 source events, one-cycle pulses
  input wire logic csma_ca_done_irq_i,
  input wire logic frame_sync_tx_done_irq_i,
  input wire logic bank1_tx_done_irq_i,
  input wire logic bank0_tx_done_irq_i,
  input wire logic calibration_done_irq_i,
  input wire logic timer_cmp2_irq_i,
  input wire logic timer_cmp1_irq_i,
  input wire logic timer_cmp0_irq_i,
  // byte 1 source events
  input wire logic frame_tx_done_irq_i,
  input wire logic rx_level_irq_i,
  input wire logic mode_switch_rx_done_irq_i,
  input wire logic rx_overrun_irq_i,
  input wire logic address_filter_irq_i,
  input wire logic frame_length_irq_i,
  input wire logic bank1_rx_done_irq_i,
  input wire logic bank0_rx_done_irq_i,
  // byte 2 source events
  input wire logic preamble_detect_irq_i,
  input wire logic clear_channel_done_irq_i,
  input wire logic gain_control_done_irq_i,
  input wire logic rx_byte_count_irq_i,
  input wire logic frame_rx_done_irq_i,
  input wire logic rx_start_irq_i,
  input wire logic tx_start_irq_i,
  input wire logic tx_byte_count_irq_i,
  // events only used by the shared slots
  input wire logic cca_clearance_irq_i,
  input wire logic rx_cancelled_irq_i,
  // request enables, same bit order as the source vector
  input wire logic [SRC_BITS-1:0] irq_enable_i,
  // enabled flags pending in source bytes 3 to 7
  input wire logic upper_pending_i,
  // reception sequencing pulses
  input wire logic rx_complete_i,
  input wire logic rx_abort_i,
  // interrupt pin
  output logic irq_out_pin_o,
  // routed slot events for the upper source bytes
  output logic slot_a_evt_o,
  output logic slot_b_evt_o,
  output logic slot_c_evt_o,
  // auto-clear pulses for the upper source bytes
  output logic rx_done_clr_o,
  output logic rx_abort_clr_o
);

  logic [7:0] mode_q;
  logic [SRC_BITS-1:0] event_vec;
  logic [SRC_BITS-1:0] set_vec;
  logic [SRC_BITS-1:0] read_clr;
  logic [SRC_BITS-1:0] auto_clr;
  logic [SRC_BITS-1:0] flags;
  logic [7:0] rd_value;
  logic rd_src_hit;
  logic [1:0] rd_src_idx;
  logic irq_level;
  logic irq_polarity_select;
  logic rx_done_auto_clear;
  logic rx_abort_auto_clear;
  logic slot_a_select;
  logic slot_b_select;
  logic slot_c_select;

  // mode register fields
  assign irq_polarity_select = mode_q[MODE_POL_BIT];
  assign rx_done_auto_clear = mode_q[MODE_DONE_CLR_BIT];
  assign rx_abort_auto_clear = mode_q[MODE_ABORT_CLR_BIT];
  assign slot_a_select = mode_q[MODE_SLOT_A_BIT];
  assign slot_b_select = mode_q[MODE_SLOT_B_BIT];
  assign slot_c_select = mode_q[MODE_SLOT_C_BIT];

  // mode register; bits 2 and 1 are kept at zero whatever is written
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mode_q <= MODE_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_OUT_MODE) begin
      mode_q <= reg_wdata_i & MODE_WR_MASK;
    end
  end

  // gather raw events into the source vector layout
  always_comb begin
    event_vec = '0;
    event_vec[F_CSMA] = csma_ca_done_irq_i;
    event_vec[F_FSYNC] = frame_sync_tx_done_irq_i;
    event_vec[F_TX1] = bank1_tx_done_irq_i;
    event_vec[F_TX0] = bank0_tx_done_irq_i;
    event_vec[F_CAL] = calibration_done_irq_i;
    event_vec[F_TIM2] = timer_cmp2_irq_i;
    event_vec[F_TIM1] = timer_cmp1_irq_i;
    event_vec[F_TIM0] = timer_cmp0_irq_i;
    event_vec[F_TXFIN] = frame_tx_done_irq_i;
    event_vec[F_RXLVL] = rx_level_irq_i;
    event_vec[F_MODESW] = mode_switch_rx_done_irq_i;
    event_vec[F_OVR] = rx_overrun_irq_i;
    event_vec[F_ADDR] = address_filter_irq_i;
    event_vec[F_FLEN] = frame_length_irq_i;
    event_vec[F_RX1] = bank1_rx_done_irq_i;
    event_vec[F_RX0] = bank0_rx_done_irq_i;
    event_vec[F_PREAMB] = preamble_detect_irq_i;
    event_vec[F_CCA] = clear_channel_done_irq_i;
    event_vec[F_AGC] = gain_control_done_irq_i;
    event_vec[F_RXBYTE] = rx_byte_count_irq_i;
    event_vec[F_RXFIN] = frame_rx_done_irq_i;
    event_vec[F_RXSTART] = rx_start_irq_i;
    event_vec[F_TXSTART] = tx_start_irq_i;
    event_vec[F_TXBYTE] = tx_byte_count_irq_i;
  end

  // only enabled requests leave a mark
  assign set_vec = event_vec & irq_enable_i;

  // read decode for the source bytes
  always_comb begin
    rd_src_hit = 1'b1;
    rd_src_idx = 2'h0;
    case (reg_addr_i)
      ADDR_SRC0: rd_src_idx = 2'h0;
      ADDR_SRC1: rd_src_idx = 2'h1;
      ADDR_SRC2: rd_src_idx = 2'h2;
      default: rd_src_hit = 1'b0;
    endcase
  end

  // value returned for the addressed register
  always_comb begin
    rd_value = RD_UNMAPPED;
    if (rd_src_hit) begin
      rd_value = flags[8*rd_src_idx +: 8];
    end else if (reg_addr_i == ADDR_OUT_MODE) begin
      rd_value = mode_q;
    end
  end

  // a read clears exactly the bits it returned as one; writes never do
  always_comb begin
    read_clr = '0;
    if (reg_rd_i && rd_src_hit) begin
      read_clr[8*rd_src_idx +: 8] = flags[8*rd_src_idx +: 8];
    end
  end

  // reception-synchronised wiping of receive flags
  always_comb begin
    auto_clr = '0;
    if (rx_complete_i && rx_done_auto_clear) begin
      auto_clr = auto_clr | DONE_CLR_MASK;
    end
    if (rx_abort_i && rx_abort_auto_clear) begin
      auto_clr = auto_clr | ABORT_CLR_MASK;
    end
  end

  // sticky flag store; contents before first event are not promised
  rif_flag_bank #(
    .NBITS(SRC_BITS)
  ) u_flags (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .set_i(set_vec),
    .clr_i(read_clr | auto_clr),
    .flags_o(flags)
  );

  // read data register; updated only on a read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= RD_UNMAPPED;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_value;
    end
  end

  // pending level over all enabled flags, own bytes and upper ones
  assign irq_level = |(flags & irq_enable_i) | upper_pending_i;

  // pin sense follows the polarity bit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      irq_out_pin_o <= 1'b0;
    end else begin
      irq_out_pin_o <= irq_level ^ irq_polarity_select;
    end
  end

  // shared slot routing; one cycle late like the flags themselves
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      slot_a_evt_o <= 1'b0;
      slot_b_evt_o <= 1'b0;
      slot_c_evt_o <= 1'b0;
    end else begin
      slot_a_evt_o <= slot_a_select ? clear_channel_done_irq_i
                                    : csma_ca_done_irq_i;
      slot_b_evt_o <= slot_b_select ? address_filter_irq_i
                                    : frame_length_irq_i;
      slot_c_evt_o <= slot_c_select ? rx_cancelled_irq_i
                                    : cca_clearance_irq_i;
    end
  end

  // forward gated wipe pulses so upper bytes clear receive flags too
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_done_clr_o <= 1'b0;
      rx_abort_clr_o <= 1'b0;
    end else begin
      rx_done_clr_o <= rx_complete_i && rx_done_auto_clear;
      rx_abort_clr_o <= rx_abort_i && rx_abort_auto_clear;
    end
  end

endmodule
`default_nettype wire

// [verification/rif_top_asserts.sv]
`default_nettype none
module rif_top_asserts
  import rif_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  input wire logic [REG_DATA_W-1:0] reg_rdata_o,
  // events and enables
  input wire logic csma_ca_done_irq_i,
  input wire logic clear_channel_done_irq_i,
  input wire logic frame_length_irq_i,
  input wire logic address_filter_irq_i,
  input wire logic cca_clearance_irq_i,
  input wire logic rx_cancelled_irq_i,
  input wire logic timer_cmp0_irq_i,
  input wire logic [SRC_BITS-1:0] irq_enable_i,
  input wire logic upper_pending_i,
  input wire logic rx_complete_i,
  input wire logic rx_abort_i,
  // outputs under watch
  input wire logic irq_out_pin_o,
  input wire logic slot_a_evt_o,
  input wire logic slot_b_evt_o,
  input wire logic slot_c_evt_o,
  input wire logic rx_done_clr_o,
  input wire logic rx_abort_clr_o
);
  logic [7:0] mode_q;
  // shadow of the mode register, reserved bits never stored
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mode_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == ADDR_OUT_MODE) begin
      mode_q <= reg_wdata_i & 8'hF9;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // flag 0 read with no fresh event in the same cycle
  sequence rd_src0;
    reg_rd_i && reg_addr_i == ADDR_SRC0 && !timer_cmp0_irq_i;
  endsequence
  sequence ev0_set;
    timer_cmp0_irq_i && irq_enable_i[F_TIM0] && !reg_wr_i ##1 !reg_wr_i;
  endsequence
  chk_slot_a_route: assert property ($past(rst_b_i) |-> slot_a_evt_o ==
    $past(mode_q[4] ? clear_channel_done_irq_i : csma_ca_done_irq_i))
    else $error("slot a routing wrong");
  chk_slot_b_route: assert property ($past(rst_b_i) |-> slot_b_evt_o ==
    $past(mode_q[5] ? address_filter_irq_i : frame_length_irq_i))
    else $error("slot b routing wrong");
  chk_slot_c_route: assert property ($past(rst_b_i) |-> slot_c_evt_o ==
    $past(mode_q[6] ? rx_cancelled_irq_i : cca_clearance_irq_i))
    else $error("slot c routing wrong");
  chk_done_clear: assert property ($past(rst_b_i) |->
    rx_done_clr_o == $past(rx_complete_i && mode_q[3]))
    else $error("completion clear pulse wrong");
  chk_abort_clear: assert property ($past(rst_b_i) |->
    rx_abort_clr_o == $past(rx_abort_i && mode_q[7]))
    else $error("cancel clear pulse wrong");
  chk_mode_readback: assert property (
    reg_rd_i && reg_addr_i == ADDR_OUT_MODE |=> reg_rdata_o == $past(mode_q))
    else $error("mode readback wrong");
  chk_pin_pending: assert property (
    (upper_pending_i && !reg_wr_i)[*3] |-> irq_out_pin_o == !mode_q[0])
    else $error("pin not asserted while pending");
  chk_flag_pin: assert property (
    ev0_set |=> irq_out_pin_o == !mode_q[0])
    else $error("pin late after enabled event");
  chk_read_clear: assert property (
    rd_src0 ##1 reg_rdata_o[0] ##0 rd_src0 |=> !reg_rdata_o[0])
    else $error("flag survived a read as one");
endmodule
bind rif_top rif_top_asserts u_chk (.*);
`default_nettype wire

// [verification/rif_host_model.sv]
`default_nettype none
module rif_host_model
  import rif_pkg::*;
(
  // clock and returned data
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  // decoded register strobes
  output logic [9:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rdv [8];
  // idle port from time zero
  initial begin
    reg_addr_o = 10'h000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // single write; mode bits 2 and 1 always sent as zero
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_o <= a;
    reg_wdata_o <= (a == ADDR_OUT_MODE) ? d & 8'hF9 : d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // back-to-back reads; a dummy read is how flags get cleared
  task automatic rd(input logic [9:0] a, input int n, input bit inc);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      reg_addr_o <= a + (inc ? 10'(i + 1) : 10'h000);
      if (i == n - 1) reg_rd_o <= 1'b0;
      #1 rdv[i] = reg_rdata_i;
    end
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`default_nettype none
module testbench
  import rif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [27:0] ev = 28'h0000000;
  logic [23:0] irq_enable_i = 24'h000000;
  logic upper_pending_i = 1'b0;
  logic [9:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic irq_out_pin_o;
  logic slot_a_evt_o;
  logic slot_b_evt_o;
  logic slot_c_evt_o;
  logic rx_done_clr_o;
  logic rx_abort_clr_o;
  logic [4:0] obs;
  logic [23:0] fl;
  logic [23:0] clr;
  int ids [8] = '{7, 22, 10, 11, 24, 25, 26, 27};
  int n_fail = 0;
  int n_tests = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  // ev bit n feeds source flag n; 24..27 are slot-only and rx pulses
  rif_top u_dut (.*,
    .csma_ca_done_irq_i(ev[7]), .frame_sync_tx_done_irq_i(ev[6]),
    .bank1_tx_done_irq_i(ev[5]), .bank0_tx_done_irq_i(ev[4]),
    .calibration_done_irq_i(ev[3]), .timer_cmp2_irq_i(ev[2]),
    .timer_cmp1_irq_i(ev[1]), .timer_cmp0_irq_i(ev[0]),
    .frame_tx_done_irq_i(ev[15]), .rx_level_irq_i(ev[14]),
    .mode_switch_rx_done_irq_i(ev[13]), .rx_overrun_irq_i(ev[12]),
    .address_filter_irq_i(ev[11]), .frame_length_irq_i(ev[10]),
    .bank1_rx_done_irq_i(ev[9]), .bank0_rx_done_irq_i(ev[8]),
    .preamble_detect_irq_i(ev[23]), .clear_channel_done_irq_i(ev[22]),
    .gain_control_done_irq_i(ev[21]), .rx_byte_count_irq_i(ev[20]),
    .frame_rx_done_irq_i(ev[19]), .rx_start_irq_i(ev[18]),
    .tx_start_irq_i(ev[17]), .tx_byte_count_irq_i(ev[16]),
    .cca_clearance_irq_i(ev[24]), .rx_cancelled_irq_i(ev[25]),
    .rx_complete_i(ev[26]), .rx_abort_i(ev[27]));
  rif_host_model u_host (.clk_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i));
  task automatic check(input string what, input logic [23:0] got,
                       input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one-cycle pulse, registered outputs caught just after the taking edge
  task automatic tap(input int b);
    ev[b] <= 1'b1;
    @(posedge clk_sys_i);
    ev[b] <= 1'b0;
    #1 obs = {slot_c_evt_o, slot_b_evt_o, slot_a_evt_o, rx_abort_clr_o,
              rx_done_clr_o};
    @(posedge clk_sys_i);
  endtask
  // raise every lower source at once, then look at the pin
  task automatic setall(input logic p);
    ev[23:0] <= 24'hFFFFFF;
    @(posedge clk_sys_i);
    ev[23:0] <= 24'h000000;
    repeat (2) @(posedge clk_sys_i);
    #1 check("pin", irq_out_pin_o, {23'h0, p});
    @(posedge clk_sys_i);
  endtask
  task automatic burst();
    u_host.rd(ADDR_SRC0, 8, 1'b1);
    fl = {u_host.rdv[2], u_host.rdv[1], u_host.rdv[0]};
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    u_host.rd(ADDR_OUT_MODE, 1, 1'b0);
    check("mode reset", u_host.rdv[0], 24'h000000);
    u_host.wr(ADDR_OUT_MODE, 8'hFF);
    u_host.rd(ADDR_OUT_MODE, 1, 1'b0);
    check("mode rw", u_host.rdv[0], 24'h0000F9);
    u_host.wr(ADDR_OUT_MODE, 8'h00);
    // disabled requests leave every flag clear
    setall(1'b0);
    burst();
    check("masked", fl, 24'h000000);
    check("unmapped", u_host.rdv[7], 24'h000000);
    irq_enable_i <= 24'hFFFFFF;
    for (int b = 0; b < 24; b++) begin
      tap(b);
      #1 check("pin set", irq_out_pin_o, 24'h000001);
      @(posedge clk_sys_i);
      burst();
      check("source bit", fl, 24'h000001 << b);
      burst();
      check("read clear", fl, 24'h000000);
    end
    // writes bounce off a source byte; an immediate re-read is clear
    tap(0);
    u_host.wr(ADDR_SRC0, 8'h00);
    u_host.rd(ADDR_SRC0, 2, 1'b0);
    check("src write", u_host.rdv[0], 24'h000001);
    check("reread", u_host.rdv[1], 24'h000000);
    u_host.wr(ADDR_OUT_MODE, 8'h01);
    #1 check("pin idle", irq_out_pin_o, 24'h000001);
    @(posedge clk_sys_i);
    upper_pending_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 check("pin low", irq_out_pin_o, 24'h000000);
    @(posedge clk_sys_i);
    upper_pending_i <= 1'b0;
    // slot routing and auto-clear, every select off then on
    for (int s = 0; s < 2; s++) begin
      u_host.wr(ADDR_OUT_MODE, s[0] ? 8'hF8 : 8'h00);
      foreach (ids[i]) begin
        setall(1'b1);
        tap(ids[i]);
        check("route", obs,
          {s ? ids[i] == 25 : ids[i] == 24,
          s ? ids[i] == 11 : ids[i] == 10, s ? ids[i] == 22 : ids[i] == 7,
          s == 1 && ids[i] == 27, s == 1 && ids[i] == 26});
        clr = (s == 1 && ids[i] == 26) ? 24'hA40C00 : 24'h000000;
        clr = (s == 1 && ids[i] == 27) ? 24'hB40F00 : clr;
        burst();
        check("auto clear", fl, ~clr);
      end
    end
    // mid-run reset with a flag pending and a non-zero mode
    tap(0);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 check("pin after reset", irq_out_pin_o, 24'h000000);
    u_host.rd(ADDR_OUT_MODE, 1, 1'b0);
    check("mode after reset", u_host.rdv[0], 24'h000000);
    end_of_test();
  end
  // hang guard, far beyond the roughly 800 cycles the run needs
  initial begin
    #1_000_000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
